// >>> fci_cfg.svh
// Function
// - 90h gives identifier data at offsets 0, 1
// - 70h makes every read return status
// - strobes return high between reads
// - erase: 20h/30h setup then D0h confirm
// - write: 40h or 10h, then address/data
// - B0h suspends, D0h resumes
// - lock: 60h then 01h, D0h or F1h
// - otp: C0h then otp address/data
// - only defined command bytes are issued
`ifndef FCI_CFG_SVH
`define FCI_CFG_SVH

`define FCI_AW            21
`define FCI_DW            16
`define FCI_SYNC_W        17

`define FCI_OFF_CMD       8'h00
`define FCI_OFF_ADDR      8'h04
`define FCI_OFF_WDATA     8'h08
`define FCI_OFF_RDATA     8'h0c
`define FCI_OFF_STATUS    8'h10
`define FCI_OFF_CTRL      8'h14

`define FCI_ST_BUSY       0
`define FCI_ST_DEVBUSY    1
`define FCI_ST_REFUSED    2
`define FCI_ST_SUSP       3
`define FCI_ST_MODE_LO    4
`define FCI_CT_HOLDRST    0
`define FCI_CT_WPLOW      1
`define FCI_RST_HOLDRST   1'b0
`define FCI_RST_WPLOW     1'b1

`define FCI_CB_READ_ARRAY 8'hff
`define FCI_CB_READ_ID    8'h90
`define FCI_CB_READ_STAT  8'h70
`define FCI_CB_CLR_STAT   8'h50
`define FCI_CB_BLK_ERASE  8'h20
`define FCI_CB_CHIP_ERASE 8'h30
`define FCI_CB_CONFIRM    8'hd0
`define FCI_CB_WRITE      8'h40
`define FCI_CB_WRITE_ALT  8'h10
`define FCI_CB_SUSPEND    8'hb0
`define FCI_CB_LOCK_SETUP 8'h60
`define FCI_CB_LOCK_BLK   8'h01
`define FCI_CB_PERM_LOCK  8'hf1
`define FCI_CB_OTP        8'hc0

`define FCI_CLK_MHZ       200
`define FCI_T_SETUP_NS    10
`define FCI_T_WP_NS       50
`define FCI_T_HOLD_NS     10
`define FCI_T_REC_NS      30
`define FCI_T_ACC_NS      90
`define FCI_SYNC_CYC      2
`define FCI_CYC(ns)       ((((ns) * `FCI_CLK_MHZ) + 999) / 1000)

`endif

// >>> fci_pkg.sv
`include "fci_cfg.svh"
package fci_pkg;

   typedef enum logic [3:0] {
      OP_READ_ARRAY,
      OP_READ_ID,
      OP_READ_STATUS,
      OP_CLEAR_STATUS,
      OP_BLOCK_ERASE,
      OP_CHIP_ERASE,
      OP_WRITE,
      OP_WRITE_ALT,
      OP_SUSPEND,
      OP_RESUME,
      OP_SET_LOCK,
      OP_CLEAR_LOCKS,
      OP_SET_PERM,
      OP_OTP,
      OP_READ,
      OP_BAD
   } fci_op_t;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_WSET,
      PH_WPUL,
      PH_WHLD,
      PH_RACC,
      PH_GAP
   } fci_phase_t;

   typedef enum logic [1:0] {
      MODE_ARRAY,
      MODE_ID,
      MODE_STATUS
   } fci_mode_t;

   typedef struct packed {
      logic               pready;
      logic               pslverr;
      logic [31:0]        prdata;
      fci_op_t            op;
      logic [`FCI_AW-1:0] addr;
      logic [`FCI_DW-1:0] wdata;
      logic [`FCI_DW-1:0] rdata;
      logic               busy;
      logic               refused;
      logic               suspended;
      fci_mode_t          mode;
      logic               holdReset;
      logic               wpLow;
      fci_phase_t         phase;
      logic [1:0]         step;
      logic [7:0]         cnt;
      logic               ceN;
      logic               oeN;
      logic               weN;
      logic               dqOe;
      logic [`FCI_DW-1:0] dqOut;
   } fci_state_t;

   typedef struct packed {
      logic [`FCI_SYNC_W-1:0] s1;
      logic [`FCI_SYNC_W-1:0] s2;
   } fci_sync_t;

endpackage

// >>> fci_sync.sv
`timescale 1ns/1ps
`include "fci_cfg.svh"
module fci_sync (
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic [`FCI_SYNC_W-1:0] din,
   output logic      [`FCI_SYNC_W-1:0] dout
);
   fci_pkg::fci_sync_t syncReg;
   fci_pkg::fci_sync_t syncNext;

   // first stage feeds only the second
   always_comb begin
      syncNext    = syncReg;
      syncNext.s1 = din;
      syncNext.s2 = syncReg.s1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         syncReg <= '1;
      end else begin
         syncReg <= syncNext;
      end
   end

   assign dout = syncReg.s2;
endmodule

// >>> fci_host.sv
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`include "fci_cfg.svh"
module fci_host (
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   output logic                    chipEnableN,
   output logic                    outputEnableN,
   output logic                    writeEnableN,
   output logic      [`FCI_AW-1:0] flashAddr,
   output logic      [`FCI_DW-1:0] dqOut,
   output logic                    dqOe,
   input  wire logic [`FCI_DW-1:0] dqIn,
   input  wire logic               ready_busy_out_n,
   output logic                    reset_powerdown_pin_n,
   output logic                    writeProtectN
);
   localparam logic [7:0] SetupCyc = 8'(`FCI_CYC(`FCI_T_SETUP_NS));
   localparam logic [7:0] PulseCyc = 8'(`FCI_CYC(`FCI_T_WP_NS));
   localparam logic [7:0] HoldCyc  = 8'(`FCI_CYC(`FCI_T_HOLD_NS));
   localparam logic [7:0] RecCyc   = 8'(`FCI_CYC(`FCI_T_REC_NS));
   // plus synchroniser delay
   localparam logic [7:0] AccCyc   = 8'(`FCI_CYC(`FCI_T_ACC_NS) + `FCI_SYNC_CYC);

   fci_pkg::fci_state_t stateReg;
   fci_pkg::fci_state_t stateNext;
   logic [`FCI_SYNC_W-1:0] pinSync;
   logic [`FCI_DW-1:0]     dqSync;
   logic                   deviceBusy;

   fci_sync u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .din    ({ready_busy_out_n, dqIn}),
      .dout   (pinSync)
   );

   assign dqSync     = pinSync[`FCI_DW-1:0];
   // open drain, pulled high when idle
   assign deviceBusy = ~pinSync[`FCI_SYNC_W-1];

   ////////////////////////////////////////////////////////////////////////////
   // command decoding

   function automatic logic [7:0] first_byte(input fci_pkg::fci_op_t op);
      unique case (op)
         fci_pkg::OP_READ_ARRAY:   first_byte = `FCI_CB_READ_ARRAY;
         fci_pkg::OP_READ_ID:      first_byte = `FCI_CB_READ_ID;
         fci_pkg::OP_READ_STATUS:  first_byte = `FCI_CB_READ_STAT;
         fci_pkg::OP_CLEAR_STATUS: first_byte = `FCI_CB_CLR_STAT;
         fci_pkg::OP_BLOCK_ERASE:  first_byte = `FCI_CB_BLK_ERASE;
         fci_pkg::OP_CHIP_ERASE:   first_byte = `FCI_CB_CHIP_ERASE;
         fci_pkg::OP_WRITE:        first_byte = `FCI_CB_WRITE;
         fci_pkg::OP_WRITE_ALT:    first_byte = `FCI_CB_WRITE_ALT;
         fci_pkg::OP_SUSPEND:      first_byte = `FCI_CB_SUSPEND;
         fci_pkg::OP_RESUME:       first_byte = `FCI_CB_CONFIRM;
         fci_pkg::OP_SET_LOCK,
         fci_pkg::OP_CLEAR_LOCKS,
         fci_pkg::OP_SET_PERM:     first_byte = `FCI_CB_LOCK_SETUP;
         fci_pkg::OP_OTP:          first_byte = `FCI_CB_OTP;
         default:                  first_byte = `FCI_CB_READ_ARRAY;
      endcase
   endfunction

   function automatic logic two_cycles(input fci_pkg::fci_op_t op);
      two_cycles = op inside {fci_pkg::OP_BLOCK_ERASE, fci_pkg::OP_CHIP_ERASE,
                              fci_pkg::OP_WRITE, fci_pkg::OP_WRITE_ALT,
                              fci_pkg::OP_SET_LOCK, fci_pkg::OP_CLEAR_LOCKS,
                              fci_pkg::OP_SET_PERM, fci_pkg::OP_OTP};
   endfunction

   function automatic logic [`FCI_DW-1:0] second_word(input fci_pkg::fci_op_t op,
                                                      input logic [`FCI_DW-1:0] wd);
      unique case (op)
         fci_pkg::OP_WRITE,
         fci_pkg::OP_WRITE_ALT,
         fci_pkg::OP_OTP:         second_word = wd;
         fci_pkg::OP_SET_LOCK:    second_word = {8'h00, `FCI_CB_LOCK_BLK};
         fci_pkg::OP_SET_PERM:    second_word = {8'h00, `FCI_CB_PERM_LOCK};
         default:                 second_word = {8'h00, `FCI_CB_CONFIRM};
      endcase
   endfunction

   function automatic logic has_read(input fci_pkg::fci_op_t op);
      has_read = op inside {fci_pkg::OP_READ_ID, fci_pkg::OP_READ_STATUS,
                            fci_pkg::OP_READ};
   endfunction

   localparam fci_pkg::fci_state_t ResetState = '{
      pready:    1'b0,
      pslverr:   1'b0,
      prdata:    '0,
      op:        fci_pkg::OP_READ_ARRAY,
      addr:      '0,
      wdata:     '0,
      rdata:     '0,
      busy:      1'b0,
      refused:   1'b0,
      suspended: 1'b0,
      mode:      fci_pkg::MODE_ARRAY,
      holdReset: `FCI_RST_HOLDRST,
      wpLow:     `FCI_RST_WPLOW,
      phase:     fci_pkg::PH_IDLE,
      step:      2'h0,
      cnt:       8'h00,
      ceN:       1'b1,
      oeN:       1'b1,
      weN:       1'b1,
      dqOe:      1'b0,
      dqOut:     '0
   };

   ////////////////////////////////////////////////////////////////////////////
   // register bus and pin sequencer

   always_comb begin
      stateNext         = stateReg;
      stateNext.pready  = 1'b0;
      stateNext.pslverr = 1'b0;

      // one wait state: ready comes from a flop
      if (psel && penable && !stateReg.pready) begin
         stateNext.pready = 1'b1;
         stateNext.prdata = '0;
         unique case (paddr)
            `FCI_OFF_CMD: begin
               stateNext.prdata[3:0] = stateReg.op;
               if (pwrite) begin
                  // reserved codes never reach the pins
                  if (stateReg.busy || stateReg.holdReset ||
                      fci_pkg::fci_op_t'(pwdata[3:0]) == fci_pkg::OP_BAD) begin
                     stateNext.refused = 1'b1;
                  end else begin
                     stateNext.refused = 1'b0;
                     stateNext.op      = fci_pkg::fci_op_t'(pwdata[3:0]);
                     stateNext.busy    = 1'b1;
                     if (fci_pkg::fci_op_t'(pwdata[3:0]) == fci_pkg::OP_READ) begin
                        stateNext.step  = 2'h2;
                        stateNext.phase = fci_pkg::PH_RACC;
                        stateNext.cnt   = AccCyc - 8'h01;
                     end else begin
                        stateNext.step  = 2'h0;
                        stateNext.phase = fci_pkg::PH_WSET;
                        stateNext.cnt   = SetupCyc - 8'h01;
                        stateNext.dqOut = {8'h00,
                                           first_byte(fci_pkg::fci_op_t'(pwdata[3:0]))};
                     end
                  end
               end
            end
            `FCI_OFF_ADDR: begin
               stateNext.prdata[`FCI_AW-1:0] = stateReg.addr;
               if (pwrite && !stateReg.busy) begin
                  stateNext.addr = pwdata[`FCI_AW-1:0];
               end
            end
            `FCI_OFF_WDATA: begin
               stateNext.prdata[`FCI_DW-1:0] = stateReg.wdata;
               if (pwrite && !stateReg.busy) begin
                  stateNext.wdata = pwdata[`FCI_DW-1:0];
               end
            end
            `FCI_OFF_RDATA: begin
               stateNext.prdata[`FCI_DW-1:0] = stateReg.rdata;
            end
            `FCI_OFF_STATUS: begin
               stateNext.prdata[`FCI_ST_BUSY]    = stateReg.busy;
               stateNext.prdata[`FCI_ST_DEVBUSY] = deviceBusy;
               stateNext.prdata[`FCI_ST_REFUSED] = stateReg.refused;
               stateNext.prdata[`FCI_ST_SUSP]    = stateReg.suspended;
               stateNext.prdata[`FCI_ST_MODE_LO +: 2] = stateReg.mode;
            end
            `FCI_OFF_CTRL: begin
               stateNext.prdata[`FCI_CT_HOLDRST] = stateReg.holdReset;
               stateNext.prdata[`FCI_CT_WPLOW]   = stateReg.wpLow;
               if (pwrite) begin
                  stateNext.holdReset = pwdata[`FCI_CT_HOLDRST];
                  stateNext.wpLow     = pwdata[`FCI_CT_WPLOW];
               end
            end
            default: begin
               stateNext.pslverr = 1'b1;
            end
         endcase
      end

      if (stateReg.cnt != 8'h00) begin
         stateNext.cnt = stateReg.cnt - 8'h01;
      end

      unique case (stateReg.phase)
         fci_pkg::PH_IDLE: begin
         end
         fci_pkg::PH_WSET: begin
            if (stateReg.cnt == 8'h00) begin
               stateNext.phase = fci_pkg::PH_WPUL;
               stateNext.cnt   = PulseCyc - 8'h01;
            end
         end
         fci_pkg::PH_WPUL: begin
            // we rises first, ce and data hold
            if (stateReg.cnt == 8'h00) begin
               stateNext.phase = fci_pkg::PH_WHLD;
               stateNext.cnt   = HoldCyc - 8'h01;
            end
         end
         fci_pkg::PH_WHLD: begin
            if (stateReg.cnt == 8'h00) begin
               stateNext.phase = fci_pkg::PH_GAP;
               stateNext.cnt   = RecCyc - 8'h01;
            end
         end
         fci_pkg::PH_RACC: begin
            if (stateReg.cnt == 8'h00) begin
               stateNext.rdata = dqSync;
               stateNext.phase = fci_pkg::PH_GAP;
               stateNext.cnt   = RecCyc - 8'h01;
            end
         end
         fci_pkg::PH_GAP: begin
            // strobes high: fresh status latch
            if (stateReg.cnt == 8'h00) begin
               if (stateReg.step == 2'h0 && two_cycles(stateReg.op)) begin
                  stateNext.step  = 2'h1;
                  stateNext.phase = fci_pkg::PH_WSET;
                  stateNext.cnt   = SetupCyc - 8'h01;
                  stateNext.dqOut = second_word(stateReg.op, stateReg.wdata);
               end else if (stateReg.step != 2'h2 && has_read(stateReg.op)) begin
                  stateNext.step  = 2'h2;
                  stateNext.phase = fci_pkg::PH_RACC;
                  stateNext.cnt   = AccCyc - 8'h01;
               end else begin
                  stateNext.phase = fci_pkg::PH_IDLE;
                  stateNext.busy  = 1'b0;
                  unique case (stateReg.op)
                     fci_pkg::OP_READ_ARRAY: begin
                        if (!deviceBusy || stateReg.suspended) begin
                           stateNext.mode = fci_pkg::MODE_ARRAY;
                        end
                     end
                     fci_pkg::OP_READ_ID:     stateNext.mode = fci_pkg::MODE_ID;
                     fci_pkg::OP_READ_STATUS: stateNext.mode = fci_pkg::MODE_STATUS;
                     fci_pkg::OP_SUSPEND: begin
                        stateNext.mode      = fci_pkg::MODE_STATUS;
                        stateNext.suspended = 1'b1;
                     end
                     fci_pkg::OP_RESUME: begin
                        stateNext.mode      = fci_pkg::MODE_STATUS;
                        stateNext.suspended = 1'b0;
                     end
                     // mode kept
                     fci_pkg::OP_CLEAR_STATUS, fci_pkg::OP_READ: begin
                     end
                     default: stateNext.mode = fci_pkg::MODE_STATUS;
                  endcase
               end
            end
         end
      endcase

      // device leaves reset in array mode
      if (stateReg.holdReset) begin
         stateNext.mode      = fci_pkg::MODE_ARRAY;
         stateNext.suspended = 1'b0;
      end

      stateNext.ceN  = !(stateNext.phase inside {fci_pkg::PH_WSET, fci_pkg::PH_WPUL,
                                                 fci_pkg::PH_WHLD, fci_pkg::PH_RACC});
      stateNext.weN  = stateNext.phase != fci_pkg::PH_WPUL;
      // never oe and we low together
      stateNext.oeN  = stateNext.phase != fci_pkg::PH_RACC;
      stateNext.dqOe = stateNext.phase inside {fci_pkg::PH_WSET, fci_pkg::PH_WPUL,
                                               fci_pkg::PH_WHLD};
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stateReg <= ResetState;
      end else begin
         stateReg <= stateNext;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata                = stateReg.prdata;
   assign pready                = stateReg.pready;
   assign pslverr               = stateReg.pslverr;
   assign chipEnableN           = stateReg.ceN;
   assign outputEnableN         = stateReg.oeN;
   assign writeEnableN          = stateReg.weN;
   assign flashAddr             = stateReg.addr;
   assign dqOut                 = stateReg.dqOut;
   assign dqOe                  = stateReg.dqOe;
   assign reset_powerdown_pin_n = !stateReg.holdReset;
   assign writeProtectN         = !stateReg.wpLow;
endmodule

// >>> fci_host_properties.sv
`timescale 1ns/1ps
module fci_host_properties (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        chipEnableN,
   input wire logic        outputEnableN,
   input wire logic        writeEnableN,
   input wire logic [20:0] flashAddr,
   input wire logic [15:0] dqOut,
   input wire logic        dqOe,
   input wire logic        reset_powerdown_pin_n,
   input wire logic        writeProtectN
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////////
   chk_apb_answer: assert property (psel && penable && !pready |=> pready && psel)
      else $error("pready late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready stuck");
   chk_unmapped_err: assert property (pready && paddr > 8'h14 |-> pslverr)
      else $error("no pslverr");
   chk_hold_reset: assert property (pready && pwrite && paddr == 8'h14 && pwdata[0]
      |=> !reset_powerdown_pin_n)
      else $error("reset pin idle");
   chk_protect_pin: assert property (pready && pwrite && paddr == 8'h14 && !pwdata[1]
      |=> writeProtectN)
      else $error("protect pin low");
   chk_pulse_len: assert property ($fell(writeEnableN) |-> !writeEnableN[*8] ##3 writeEnableN)
      else $error("we width");
   chk_latch_hold: assert property ($rose(writeEnableN)
      |-> !chipEnableN && dqOe && $stable(dqOut) && $stable(flashAddr))
      else $error("latch moved");
   chk_we_select: assert property (!writeEnableN |-> !chipEnableN && dqOe && outputEnableN)
      else $error("we misuse");
   chk_read_hold: assert property ($fell(outputEnableN)
      |-> (!outputEnableN && !chipEnableN && !dqOe && writeEnableN)[*8])
      else $error("read short");
   chk_read_gap: assert property ($rose(outputEnableN) |-> (outputEnableN && chipEnableN)[*6])
      else $error("no read gap");
endmodule

// >>> fci_flash_model.sv
`timescale 1ns/1ps
module fci_flash_model #(
   parameter int         BUSY_CYC   = 40,
   parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary value
   parameter logic [7:0] PART_CODE  = 8'h7e  // arbitrary value
) (
   input  wire logic        clk,
   input  wire logic        ceN,
   input  wire logic        oeN,
   input  wire logic        weN,
   input  wire logic        rstN,
   input  wire logic        wpN,
   input  wire logic [20:0] addr,
   input  wire logic [15:0] hostDq,
   input  wire logic        hostOe,
   output logic      [15:0] dq,
   output logic             rbN
);
   logic [15:0] mem [16];
   logic [63:0] lockBits = 64'h0;
   logic        perm = 1'b0, susp = 1'b0, eErr = 1'b0, wErr = 1'b0, lErr = 1'b0;
   logic        tog = 1'b0, seen = 1'b0, busy, lockedBlk;
   logic [1:0]  mode = 2'h0;
   logic [7:0]  first = 8'h00, sr, srLatch = 8'h00;
   logic [20:0] la = 21'h0;
   logic [15:0] ld = 16'h0, val, last = 16'h0;
   int          busyCnt = 0;
   initial foreach (mem[i]) mem[i] = 16'hffff;
   assign busy = busyCnt != 0;
   assign lockedBlk = lockBits[la[20:15]] || (la[20:15] == 6'h0 && !wpN);
   assign sr = {!busy || susp, susp, eErr, wErr, 2'b00, lErr, 1'b0};
   assign rbN = !(busy && !susp);
   // released dq shows the inverse, so a stale value never passes
   assign dq = hostOe ? hostDq : (!ceN && !oeN && rstN) ? val : ~last;
   always @(negedge oeN or negedge ceN) srLatch <= sr;
   always @(posedge weN or posedge ceN) begin
      if (!ceN || !weN) begin
         la <= addr;
         ld <= hostDq;
         tog <= !tog;
      end
   end
   always @(posedge clk) if (!ceN && !oeN) last <= val;
   always_comb begin
      case (mode)
         2'h0: val = mem[addr[3:0]];
         2'h1: val = addr == 21'h0 ? {8'h00, MAKER_CODE} : addr == 21'h1 ? {8'h00, PART_CODE}
            : addr == 21'h3 ? {15'h0, perm}
            : addr[14:0] == 15'h2 ? {15'h0, lockBits[addr[20:15]]} : 16'h0;
         default: val = {8'h00, srLatch};
      endcase
   end
   // decode a clock after latch; gap is longer
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         mode <= 2'h0;
         first <= 8'h00;
         susp <= 1'b0;
         busyCnt <= 0;
      end else begin
         if (busy && !susp) busyCnt <= busyCnt - 1;
         if (seen != tog) begin
            seen <= tog;
            first <= 8'h00;
            case (first)
               8'h20, 8'h30: begin
                  mode <= 2'h2;
                  if (ld[7:0] != 8'hd0) {eErr, wErr} <= 2'b11;
                  else if (first == 8'h20 && lockedBlk) {eErr, lErr} <= 2'b11;
                  else begin
                     busyCnt <= BUSY_CYC;
                     foreach (mem[i]) mem[i] <= 16'hffff;
                  end
               end
               8'h40, 8'h10: begin
                  mode <= 2'h2;
                  busyCnt <= BUSY_CYC;
                  if (lockedBlk) {wErr, lErr} <= 2'b11;
                  else mem[la[3:0]] <= mem[la[3:0]] & ld;
               end
               8'hc0: begin
                  mode <= 2'h2;
                  busyCnt <= BUSY_CYC;
               end
               8'h60: begin
                  mode <= 2'h2;
                  busyCnt <= BUSY_CYC;
                  if (ld[7:0] == 8'hf1) perm <= 1'b1;
                  else if (!perm && ld[7:0] == 8'h01) lockBits[la[20:15]] <= 1'b1;
                  else if (!perm && ld[7:0] == 8'hd0) lockBits <= 64'h0;
               end
               default: begin
                  case (ld[7:0])
                     8'hff: if (!busy || susp) mode <= 2'h0;
                     8'h90: mode <= 2'h1;
                     8'h70: mode <= 2'h2;
                     8'h50: if (!susp) {eErr, wErr, lErr} <= 3'b000;
                     8'hb0: if (busy) {susp, mode} <= 3'b110;
                     8'hd0: {susp, mode} <= 3'b010;
                     8'h20, 8'h30, 8'h40, 8'h10, 8'h60, 8'hc0: first <= ld[7:0];
                     default: ;
                  endcase
               end
            endcase
         end
      end
   end
endmodule

// >>> fci_host_bench.sv
`timescale 1ns/1ps
`include "fci_cfg.svh"
module fci_host_bench;
   logic               clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]         paddr = 8'h00;
   logic [31:0]        pwdata = 32'h0, prdata, r;
   logic               pready, pslverr, e, ceN, oeN, weN, dqOe, rbN, rpN, wpN;
   logic [`FCI_AW-1:0] fAddr;
   logic [`FCI_DW-1:0] dqOut, dqIn;
   int                 num_errors = 0, tests_run = 0;
   // op, addr, wdata, check, rdata, mode
   localparam logic [67:0] ROWS [0:28] = '{
      68'h1_000000_0000_1_003c_1, 68'h1_000001_0000_1_007e_1, 68'h1_000003_0000_1_0000_1,
      68'ha_008000_0000_0_0000_0, 68'h1_008002_0000_1_0001_1, 68'h6_008005_1234_0_0000_0,
      68'h2_000000_0000_1_0092_2, 68'h3_000000_0000_0_0000_0, 68'h2_000000_0000_1_0080_2,
      68'hb_000000_0000_0_0000_0, 68'h1_008002_0000_1_0000_1, 68'h6_008005_1234_0_0000_0,
      68'h0_000000_0000_0_0000_0, 68'he_008005_0000_1_1234_0, 68'h7_008006_00f0_0_0000_0,
      68'he_008006_0000_1_0080_2, 68'h4_008000_0000_0_0000_0, 68'h0_000000_0000_0_0000_0,
      68'he_008005_0000_1_ffff_0, 68'h6_000000_aaaa_0_0000_0, 68'h2_000000_0000_1_0092_2,
      68'h3_000000_0000_0_0000_0, 68'hd_008100_5555_0_0000_0, 68'h2_000000_0000_1_0080_2,
      68'h5_000000_0000_0_0000_0, 68'h2_000000_0000_1_0080_2, 68'hc_000000_0000_0_0000_0,
      68'ha_008000_0000_0_0000_0, 68'h1_008002_0000_1_0000_1};
   always #2.5 clk = ~clk;
   fci_host fci_host_i (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chipEnableN(ceN), .outputEnableN(oeN), .writeEnableN(weN),
      .flashAddr(fAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn), .ready_busy_out_n(rbN),
      .reset_powerdown_pin_n(rpN), .writeProtectN(wpN));
   fci_flash_model #(.BUSY_CYC(120)) fci_flash_model_i (.clk(clk), .ceN(ceN), .oeN(oeN),
      .weN(weN), .rstN(rpN), .wpN(wpN), .addr(fAddr), .hostDq(dqOut), .hostOe(dqOe),
      .dq(dqIn), .rbN(rbN));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("tests %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task automatic hang();
      num_errors++;
      $display("unexpected at %0t: no answer", $time);
      close_out();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) hang();
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // m: busy bits to wait out
   task automatic op(input logic [3:0] c, input logic [20:0] a, input logic [15:0] d,
                     input logic [1:0] m);
      int n;
      apb(1'b1, 8'h04, {11'h0, a});
      apb(1'b1, 8'h08, {16'h0, d});
      apb(1'b1, 8'h00, {28'h0, c});
      n = 0;
      do begin
         apb(1'b0, 8'h10, 32'h0);
         n++;
      end while ((r[1:0] & m) !== 2'b00 && n < 100);
      if (n >= 100) hang();
   endtask
   task automatic pulse_reset();
      arst_n <= 1'b0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
   endtask
   initial begin
      pulse_reset();
      foreach (ROWS[i]) begin
         op(ROWS[i][67:64], ROWS[i][60:40], ROWS[i][39:24], 2'b11);
         if (ROWS[i][20]) begin
            cmp({30'h0, r[5:4]}, {30'h0, ROWS[i][1:0]});
            apb(1'b0, 8'h0c, 32'h0);
            cmp(r, {16'h0, ROWS[i][19:4]});
         end
      end
      $display("rows done");
      pulse_reset();
      apb(1'b0, 8'h10, 32'h0);
      cmp(r, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      cmp(r, 32'h2);
      cmp({30'h0, rpN, wpN}, 32'h2);
      apb(1'b0, 8'h20, 32'h0);
      cmp({31'h0, e}, 32'h1);
      $display("reset done");
      op(4'h6, 21'h008005, 16'h1234, 2'b01);
      cmp({31'h0, r[1]}, 32'h1);
      op(4'h0, 21'h0, 16'h0, 2'b01);
      op(4'he, 21'h008005, 16'h0, 2'b01);
      cmp({30'h0, r[5:4]}, 32'h2);
      apb(1'b0, 8'h0c, 32'h0);
      cmp(r, 32'h0);
      $display("busy done");
      // suspend live write, try clear
      op(4'h6, 21'h0, 16'h0f0f, 2'b11);
      op(4'h6, 21'h008007, 16'h1111, 2'b01);
      op(4'h8, 21'h0, 16'h0, 2'b01);
      cmp({31'h0, r[1]}, 32'h0);
      op(4'h3, 21'h0, 16'h0, 2'b01);
      op(4'h2, 21'h0, 16'h0, 2'b01);
      apb(1'b0, 8'h0c, 32'h0);
      cmp(r, 32'hd2);
      op(4'h9, 21'h0, 16'h0, 2'b01);
      cmp({31'h0, r[1]}, 32'h1);
      op(4'h3, 21'h0, 16'h0, 2'b11);
      op(4'h2, 21'h0, 16'h0, 2'b11);
      apb(1'b0, 8'h0c, 32'h0);
      cmp(r, 32'h80);
      $display("suspend done");
      op(4'h1, 21'h0, 16'h0, 2'b11);
      apb(1'b1, 8'h14, 32'h3);
      cmp({31'h0, rpN}, 32'h0);
      apb(1'b1, 8'h00, 32'h2);
      apb(1'b0, 8'h10, 32'h0);
      cmp(r & 32'h34, 32'h4);
      apb(1'b1, 8'h14, 32'h2);
      op(4'he, 21'h008005, 16'h0, 2'b11);
      apb(1'b0, 8'h0c, 32'h0);
      cmp(r, 32'h1234);
      $display("hold reset done");
      close_out();
   end
endmodule
bind fci_host fci_host_properties fci_host_properties_i (.clk(clk), .arst_n(arst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .chipEnableN(chipEnableN),
   .outputEnableN(outputEnableN), .writeEnableN(writeEnableN), .flashAddr(flashAddr),
   .dqOut(dqOut), .dqOe(dqOe), .reset_powerdown_pin_n(reset_powerdown_pin_n),
   .writeProtectN(writeProtectN));
